// File: design/io_space_register_access.v
// Low I/O space register bank with I/O, bit and data-space access.
`timescale 1ns/10ps
`include "io_space_consts.vh"
module io_space_register_access (
  input wire sys_clk,
  input wire reset,
  input wire [2:0] ioOp,
  input wire [5:0] ioAddr,
  input wire [2:0] ioBit,
  input wire [7:0] ioWrData,
  input wire dataRd,
  input wire dataWr,
  input wire [7:0] dataAddr,
  input wire [7:0] dataWrData,
  input wire [7:0] gpio_b_pin_input,
  input wire [6:0] gpio_c_pin_input,
  input wire [7:0] gpio_d_pin_input,
  input wire [7:0] timer0Event,
  input wire [7:0] timer1Event,
  input wire [7:0] timer2Event,
  input wire [7:0] pinChangeEvent,
  output reg [7:0] rdData_reg,
  output reg rdValid_reg,
  output reg skip_reg,
  output reg dataHit_reg,
  output reg [7:0] dirB_reg,
  output reg [7:0] outB_reg,
  output reg [6:0] dirC_reg,
  output reg [6:0] outC_reg,
  output reg [7:0] dirD_reg,
  output reg [7:0] outD_reg,
  output reg [7:0] timer0Flags_reg,
  output reg [7:0] timer1Flags_reg,
  output reg [7:0] timer2Flags_reg,
  output reg [7:0] pinChangeFlags_reg
);
  wire [7:0] f0;
  wire [7:0] f1;
  wire [7:0] f2;
  wire [7:0] fp;
  reg [7:0] clr0;
  reg [7:0] clr1;
  reg [7:0] clr2;
  reg [7:0] clrP;
  reg wrEn;
  reg [5:0] wrAddr;
  reg [7:0] wrByte;
  reg isBitOp;
  reg [7:0] bitMask;
  reg rdEn;
  reg [5:0] rdAddr;
  reg [7:0] rdByte;
  reg inIoData;
  reg [7:0] ioFromData;

  // Readback of one I/O location; unmapped locations read zero.
  function [7:0] readIo;
    input [5:0] a;
    begin
      case (a)
        `OFS_GPB_IN: readIo = gpio_b_pin_input;
        `OFS_GPB_DIR: readIo = dirB_reg;
        `OFS_GPB_OUT: readIo = outB_reg;
        `OFS_GPC_IN: readIo = {1'b0, gpio_c_pin_input};
        `OFS_GPC_DIR: readIo = {1'b0, dirC_reg};
        `OFS_GPC_OUT: readIo = {1'b0, outC_reg};
        `OFS_GPD_IN: readIo = gpio_d_pin_input;
        `OFS_GPD_DIR: readIo = dirD_reg;
        `OFS_GPD_OUT: readIo = outD_reg;
        `OFS_TMR0F: readIo = f0;
        `OFS_TMR1F: readIo = f1;
        `OFS_TMR2F: readIo = f2;
        `OFS_PCF: readIo = fp;
        default: readIo = 8'h00;
      endcase
    end
  endfunction

  // Decode of the access into one write port and one read port.
  always @* begin
    ioFromData = 8'h00;
    inIoData = (dataAddr >= `DATA_IO_OFFSET) && (dataAddr < `DATA_EXT_LO);
    ioFromData = dataAddr - `DATA_IO_OFFSET;
    wrEn = 1'b0;
    wrAddr = ioAddr;
    wrByte = ioWrData;
    isBitOp = 1'b0;
    bitMask = 8'h01 << ioBit;
    rdEn = 1'b0;
    rdAddr = ioAddr;
    case (ioOp)
      `OP_IN: begin
        rdEn = 1'b1;
      end
      `OP_OUT: begin
        wrEn = 1'b1;
      end
      `OP_SET, `OP_CLR: begin
        wrEn = (ioAddr <= `BIT_IO_LAST);
        isBitOp = 1'b1;
      end
      `OP_SKIP1, `OP_SKIP0: begin
        rdEn = (ioAddr <= `BIT_IO_LAST);
      end
      default: begin
        if (dataWr && inIoData) begin
          wrEn = 1'b1;
          wrAddr = ioFromData[5:0];
          wrByte = dataWrData;
        end
        if (dataRd && inIoData) begin
          rdEn = 1'b1;
          rdAddr = ioFromData[5:0];
        end
      end
    endcase
    rdByte = readIo(rdAddr);
    // A bit op builds the new byte from the current value for plain bits.
    if (isBitOp) begin
      if (ioOp == `OP_SET) begin
        wrByte = readIo(wrAddr) | bitMask;
      end else begin
        wrByte = readIo(wrAddr) & ~bitMask;
      end
    end
  end

  // Flag clears: a bit op clears a flag only by setting that bit.
  always @* begin
    clr0 = 8'h00;
    clr1 = 8'h00;
    clr2 = 8'h00;
    clrP = 8'h00;
    if (wrEn) begin
      case (wrAddr)
        `OFS_TMR0F: clr0 = isBitOp ? clrBit(ioOp, bitMask) : wrByte;
        `OFS_TMR1F: clr1 = isBitOp ? clrBit(ioOp, bitMask) : wrByte;
        `OFS_TMR2F: clr2 = isBitOp ? clrBit(ioOp, bitMask) : wrByte;
        `OFS_PCF: clrP = isBitOp ? clrBit(ioOp, bitMask) : wrByte;
        default: clr0 = 8'h00;
      endcase
    end
  end

  // Setting a flag bit by a bit op is the write of a one, which clears it.
  function [7:0] clrBit;
    input [2:0] op;
    input [7:0] m;
    begin
      clrBit = (op == `OP_SET) ? m : 8'h00;
    end
  endfunction

  w1c_flag_reg #(.MASK(`MASK_TMR0F)) uFlag0 (
    .sys_clk(sys_clk), .reset(reset), .setEvent(timer0Event),
    .clearBits(clr0), .flags_reg(f0));
  w1c_flag_reg #(.MASK(`MASK_TMR1F)) uFlag1 (
    .sys_clk(sys_clk), .reset(reset), .setEvent(timer1Event),
    .clearBits(clr1), .flags_reg(f1));
  w1c_flag_reg #(.MASK(`MASK_TMR2F)) uFlag2 (
    .sys_clk(sys_clk), .reset(reset), .setEvent(timer2Event),
    .clearBits(clr2), .flags_reg(f2));
  w1c_flag_reg #(.MASK(`MASK_PCF)) uFlagP (
    .sys_clk(sys_clk), .reset(reset), .setEvent(pinChangeEvent),
    .clearBits(clrP), .flags_reg(fp));

  // Output copies of the flags keep every output on a flip-flop.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timer0Flags_reg <= `RESET_BYTE;
      timer1Flags_reg <= `RESET_BYTE;
      timer2Flags_reg <= `RESET_BYTE;
      pinChangeFlags_reg <= `RESET_BYTE;
    end else begin
      timer0Flags_reg <= f0;
      timer1Flags_reg <= f1;
      timer2Flags_reg <= f2;
      pinChangeFlags_reg <= fp;
    end
  end

  // Plain read/write registers; reserved addresses and bits ignore writes.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dirB_reg <= `RESET_BYTE;
      outB_reg <= `RESET_BYTE;
      dirC_reg <= 7'h00;
      outC_reg <= 7'h00;
      dirD_reg <= `RESET_BYTE;
      outD_reg <= `RESET_BYTE;
    end else if (wrEn) begin
      case (wrAddr)
        `OFS_GPB_DIR: dirB_reg <= wrByte;
        `OFS_GPB_OUT: outB_reg <= wrByte;
        `OFS_GPC_DIR: dirC_reg <= wrByte[6:0];
        `OFS_GPC_OUT: outC_reg <= wrByte[6:0];
        `OFS_GPD_DIR: dirD_reg <= wrByte;
        `OFS_GPD_OUT: outD_reg <= wrByte;
        default: dirB_reg <= dirB_reg;
      endcase
    end
  end

  // Read answer, skip decision and extended-space hit, one cycle later.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdData_reg <= 8'h00;
      rdValid_reg <= 1'b0;
      skip_reg <= 1'b0;
      dataHit_reg <= 1'b0;
    end else begin
      rdData_reg <= rdEn ? rdByte : 8'h00;
      rdValid_reg <= rdEn;
      skip_reg <= rdEn && (((ioOp == `OP_SKIP1) && |(rdByte & bitMask)) ||
        ((ioOp == `OP_SKIP0) && !(|(rdByte & bitMask))));
      // Extended region belongs to load/store only; flagged for the owner.
      dataHit_reg <= (ioOp == `OP_NONE) && (dataRd || dataWr) &&
        (dataAddr >= `DATA_EXT_LO);
    end
  end
endmodule

// File: include/io_space_consts.vh
// Constants for the low I/O register space decoder.
`ifndef IO_SPACE_CONSTS_VH
`define IO_SPACE_CONSTS_VH
`define IO_ADDR_W 6
`define IO_LOCATIONS 64
`define DATA_ADDR_W 8
`define DATA_IO_OFFSET 8'h20
`define DATA_EXT_LO 8'h60
`define DATA_EXT_HI 8'hff
`define BIT_IO_LAST 6'h1f
`define OFS_GPB_IN 6'h03
`define OFS_GPB_DIR 6'h04
`define OFS_GPB_OUT 6'h05
`define OFS_GPC_IN 6'h06
`define OFS_GPC_DIR 6'h07
`define OFS_GPC_OUT 6'h08
`define OFS_GPD_IN 6'h09
`define OFS_GPD_DIR 6'h0a
`define OFS_GPD_OUT 6'h0b
`define OFS_TMR0F 6'h15
`define OFS_TMR1F 6'h16
`define OFS_TMR2F 6'h17
`define OFS_PCF 6'h1b
`define MASK_GPC_OUT 8'h7f
`define MASK_TMR0F 8'h07
`define MASK_TMR1F 8'h27
`define MASK_TMR2F 8'h07
`define MASK_PCF 8'h07
`define RESET_BYTE 8'h00
`define OP_NONE 3'h0
`define OP_IN 3'h1
`define OP_OUT 3'h2
`define OP_SET 3'h3
`define OP_CLR 3'h4
`define OP_SKIP1 3'h5
`define OP_SKIP0 3'h6
`endif

// File: design/w1c_flag_reg.v
// One byte of write-one-to-clear event flags.
`timescale 1ns/10ps
module w1c_flag_reg #(
  parameter [7:0] MASK = 8'hff
) (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] setEvent,
  input wire [7:0] clearBits,
  output reg [7:0] flags_reg
);
  // Set wins over clear so an event in the clearing cycle is kept.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= ((flags_reg & ~clearBits) | setEvent) & MASK;
    end
  end
endmodule

// File: tb/io_space_chk.sv
// Port checker for the low I/O space decoder.
`timescale 1ns/10ps
module io_space_chk (
  input logic sys_clk,
  input logic reset,
  input logic dataRd,
  input logic dataWr,
  input logic skip_reg,
  input logic rdValid_reg,
  input logic dataHit_reg,
  input logic [2:0] ioOp,
  input logic [2:0] ioBit,
  input logic [5:0] ioAddr,
  input logic [7:0] ioWrData,
  input logic [7:0] dataAddr,
  input logic [7:0] dataWrData,
  input logic [7:0] timer0Event,
  input logic [7:0] rdData_reg,
  input logic [7:0] dirB_reg,
  input logic [7:0] outD_reg,
  input logic [7:0] timer0Flags_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Accesses and the port values they must leave behind.
  chk_bit_range: assert property (
    ioOp == 3'h5 && ioAddr > 6'h1f |=> !skip_reg)
    else $error("skip above bit range");
  chk_skip_test: assert property (
    ioOp == 3'h5 && ioAddr == 6'h0b |=> skip_reg == outD_reg[$past(ioBit)])
    else $error("skip result wrong");
  chk_out_write: assert property (
    ioOp == 3'h2 && ioAddr == 6'h04 |=> dirB_reg == $past(ioWrData))
    else $error("output write lost");
  chk_data_map: assert property (
    ioOp == 3'h0 && dataWr && dataAddr == 8'h2b
    |=> outD_reg == $past(dataWrData))
    else $error("data space store misplaced");
  chk_ext_only: assert property (
    ioOp == 3'h0 && (dataRd || dataWr) && dataAddr >= 8'h60
    |=> dataHit_reg && !rdValid_reg)
    else $error("extended access served");
  chk_rsvd_read: assert property (
    ioOp == 3'h1 && ioAddr >= 6'h0c && ioAddr <= 6'h14
    |=> rdValid_reg && rdData_reg == 8'h00)
    else $error("reserved read not zero");
  chk_w1c_clear: assert property (
    ioOp == 3'h2 && ioAddr == 6'h15 && ioWrData == 8'h07
    && timer0Event == 8'h00 |=> ##1 timer0Flags_reg == 8'h00)
    else $error("flags not cleared");
  chk_bit_only: assert property (
    ioOp == 3'h3 && ioAddr == 6'h0b
    |=> outD_reg == ($past(outD_reg) | (8'h01 << $past(ioBit))))
    else $error("bit set touched other bits");
endmodule
bind io_space_register_access io_space_chk chk (.sys_clk, .reset,
  .dataRd, .dataWr, .skip_reg, .rdValid_reg, .dataHit_reg, .ioOp, .ioBit,
  .ioAddr, .ioWrData, .dataAddr, .dataWrData, .timer0Event, .rdData_reg,
  .dirB_reg, .outD_reg, .timer0Flags_reg);

// File: tb/core_model.sv
// Behavioural processor core issuing I/O and data accesses.
`timescale 1ns/10ps
module core_model (
  input logic sys_clk,
  output logic [2:0] ioOp,
  output logic [2:0] ioBit,
  output logic [5:0] ioAddr,
  output logic [7:0] ioWrData,
  output logic [7:0] dataAddr,
  output logic [7:0] dataWrData,
  output logic dataRd,
  output logic dataWr
);
  // Idle bus from time zero.
  initial begin
    {ioOp, ioBit, ioAddr, ioWrData} = 0;
    {dataAddr, dataWrData, dataRd, dataWr} = 0;
  end
  // One instruction; its answer stands on the ports when this returns.
  task io(input [2:0] op, input [5:0] a, input [2:0] b, input [7:0] d);
    @(negedge sys_clk);
    ioOp = op;
    ioAddr = a;
    ioBit = b;
    ioWrData = d;
    @(negedge sys_clk);
    ioOp = 3'h0;
    ioWrData = ~d;
  endtask
  // One data-space load or store at a data address.
  task dat(input w, input [7:0] a, input [7:0] d);
    @(negedge sys_clk);
    dataWr = w;
    dataRd = !w;
    dataAddr = a;
    dataWrData = d;
    @(negedge sys_clk);
    dataWr = 1'b0;
    dataRd = 1'b0;
  endtask
endmodule

// File: tb/io_space_register_access_tb.sv
// Self-checking bench for the low I/O space decoder.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  miscompares++; $display("Error %0t: got %h want %h", $time, a, b); end end
module io_space_register_access_tb;
  logic sys_clk = 0, reset = 1;
  logic [7:0] gpio_b_pin_input = 8'h3c, gpio_d_pin_input = 0, timer0Event = 0, timer1Event = 0;
  logic [7:0] timer2Event = 0, pinChangeEvent = 0;
  logic [6:0] gpio_c_pin_input = 7'h2a;
  wire [2:0] ioOp, ioBit;
  wire [5:0] ioAddr;
  wire [7:0] ioWrData, dataAddr, dataWrData, rdData_reg, dirB_reg, outB_reg;
  wire [7:0] dirD_reg, outD_reg, timer0Flags_reg, timer1Flags_reg;
  wire [7:0] timer2Flags_reg, pinChangeFlags_reg;
  wire [6:0] dirC_reg, outC_reg;
  wire dataRd, dataWr, rdValid_reg, skip_reg, dataHit_reg;
  int comparisons = 0, miscompares = 0;
  io_space_register_access uut (.*);
  core_model cpu (.*);
  // Half period of 2 ns gives the 250 MHz clock.
  always #2 sys_clk = ~sys_clk;
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reset values, an output write, an input read and reserved places.
  task t_io;
    `CHK(dirB_reg, 8'h00)
    cpu.io(3'h2, 6'h04, 3'h0, 8'ha5);
    `CHK(dirB_reg, 8'ha5)
    cpu.io(3'h1, 6'h03, 3'h0, 8'h00);
    `CHK(rdData_reg, 8'h3c)
    // Reserved locations are only read here; writing them is not allowed.
    cpu.io(3'h1, 6'h13, 3'h0, 8'h00);
    `CHK(rdData_reg, 8'h00)
    cpu.io(3'h1, 6'h0c, 3'h0, 8'h00);
    `CHK(rdData_reg, 8'h00)
    cpu.io(3'h2, 6'h05, 3'h0, 8'h3c);
    `CHK(outB_reg, 8'h3c)
    cpu.io(3'h2, 6'h07, 3'h0, 8'h55);
    `CHK(dirC_reg, 7'h55)
    cpu.io(3'h2, 6'h0a, 3'h0, 8'hc3);
    `CHK(dirD_reg, 8'hc3)
    cpu.io(3'h1, 6'h06, 3'h0, 8'h00);
    `CHK(rdData_reg, 8'h2a)
    cpu.io(3'h1, 6'h3f, 3'h0, 8'h00);
    `CHK({rdValid_reg, rdData_reg}, 9'h100)
  endtask
  // Store and load through the data-space alias, then low and high data.
  task t_data;
    cpu.dat(1'b1, 8'h2b, 8'h5a);
    `CHK(outD_reg, 8'h5a)
    cpu.dat(1'b0, 8'h24, 8'h00);
    `CHK(rdData_reg, 8'ha5)
    cpu.dat(1'b1, 8'h28, 8'h19);
    `CHK(outC_reg, 7'h19)
    cpu.dat(1'b1, 8'h0b, 8'hff);
    `CHK(outD_reg, 8'h5a)
    cpu.dat(1'b0, 8'h80, 8'h00);
    `CHK({dataHit_reg, rdValid_reg}, 2'b10)
  endtask
  // Single-bit set, clear and skip in the bit range, and a skip above it.
  task t_bits;
    cpu.io(3'h3, 6'h0b, 3'h7, 8'h00);
    `CHK(outD_reg, 8'hda)
    cpu.io(3'h4, 6'h0b, 3'h1, 8'h00);
    `CHK(outD_reg, 8'hd8)
    cpu.io(3'h5, 6'h0b, 3'h3, 8'h00);
    `CHK(skip_reg, 1'b1)
    cpu.io(3'h6, 6'h0b, 3'h0, 8'h00);
    `CHK(skip_reg, 1'b1)
    cpu.io(3'h6, 6'h0b, 3'h3, 8'h00);
    `CHK(skip_reg, 1'b0)
    cpu.io(3'h5, 6'h2b, 3'h3, 8'h00);
    `CHK(skip_reg, 1'b0)
  endtask
  // Flags are set by events and cleared only by writing ones.
  task t_flags;
    @(negedge sys_clk);
    {timer0Event, timer1Event, timer2Event, pinChangeEvent} = '1;
    @(negedge sys_clk);
    {timer0Event, timer1Event, timer2Event, pinChangeEvent} = '0;
    @(negedge sys_clk);
    `CHK({timer0Flags_reg, timer1Flags_reg}, 16'h0727)
    `CHK({timer2Flags_reg, pinChangeFlags_reg}, 16'h0707)
    cpu.io(3'h3, 6'h15, 3'h1, 8'h00);
    @(negedge sys_clk);
    `CHK(timer0Flags_reg, 8'h05)
    cpu.io(3'h4, 6'h15, 3'h2, 8'h00);
    @(negedge sys_clk);
    `CHK(timer0Flags_reg, 8'h05)
    cpu.io(3'h2, 6'h15, 3'h0, 8'h00);
    @(negedge sys_clk);
    `CHK(timer0Flags_reg, 8'h05)
    cpu.io(3'h2, 6'h15, 3'h0, 8'h07);
    @(negedge sys_clk);
    `CHK(timer0Flags_reg, 8'h00)
  endtask
  // Main sequence; writes keep reserved bits at zero throughout.
  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 0;
    t_io();
    t_data();
    t_bits();
    t_flags();
    wrap_up();
  end
  // The run needs about 58 cycles, so 500 cycles means a hang.
  initial begin
    #2000;
    miscompares++;
    wrap_up();
  end
endmodule
